/* File: pxc_map.vh */
// constant map for the prioritized exception controller
// assumes one 125 MHz clock, synchronous reset and an AXI4-Lite master
`ifndef PXC_MAP_VH
`define PXC_MAP_VH
`define PXC_OFS_CTRL 8'h00
`define PXC_OFS_STAT 8'h04
`define PXC_OFS_SYSPRI 8'h08
`define PXC_OFS_IRQEN0 8'h0C
`define PXC_OFS_IRQEN1 8'h10
`define PXC_OFS_PEND0 8'h14
`define PXC_OFS_PEND1 8'h18
`define PXC_OFS_IRQPRI 8'h20
`define PXC_OFS_IRQPRI_END 8'h34
`define PXC_CTRL_NMI 0
`define PXC_CTRL_PSVSET 1
`define PXC_CTRL_PSVCLR 2
`define PXC_CTRL_BUSEN 3
`define PXC_CTRL_MEMEN 4
`define PXC_CTRL_USGEN 5
`define PXC_CTRL_DBGEN 6
`define PXC_CTRL_GRP_LSB 8
`define PXC_PRIO_RST 3'h0
`define PXC_IMPL_MASK 48'h0801F3FFDFFF
`define PXC_VEC_SP 6'h00
`define PXC_VEC_RST 6'h01
`define PXC_VEC_NMI 6'h02
`define PXC_VEC_HARD 6'h03
`define PXC_VEC_MEM 6'h04
`define PXC_VEC_BUS 6'h05
`define PXC_VEC_USG 6'h06
`define PXC_VEC_SVC 6'h0B
`define PXC_VEC_DBG 6'h0C
`define PXC_VEC_PSV 6'h0E
`define PXC_VEC_TICK 6'h0F
`define PXC_VEC_IRQ0 6'h10
`define PXC_RANK_BASE 5'h1F
`define PXC_FIXED_LEVELS 5'h03
`define PXC_STACK_WORDS 4'h8
`define PXC_RESP_OKAY 2'h0
`define PXC_RESP_SLVERR 2'h2
`endif

/* File: pxc_ctrl.v */
// exception prioritizer and entry/return sequencer for a processor core
// assumes core strobes are on mclk; peripheral lines are asynchronous
`include "pxc_map.vh"
module pxc_ctrl #(
   parameter NIRQ = 48,
   parameter STACK_WORDS = `PXC_STACK_WORDS
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // event sources
   input wire [NIRQ-1:0] irqLine,
   input wire memFault,
   input wire busFaultPrecise,
   input wire busFaultImprecise,
   input wire usageFault,
   input wire svcInstr,
   input wire debugMonReq,
   input wire sysTickFire,
   // core side
   input wire excReturn,
   output reg stackPush_ff,
   output reg stackPop_ff,
   output reg vecFetch_ff,
   output reg [5:0] vecNum_ff,
   output reg spLoad_ff,
   output reg handlerMode_ff
);
   localparam NVEC = 64;
   localparam S_BOOT = 2'd0;
   localparam S_RUN = 2'd1;
   localparam S_PUSH = 2'd2;
   localparam S_POP = 2'd3;
   localparam [47:0] IMPL = `PXC_IMPL_MASK;
   localparam [3:0] STACK_CNT = STACK_WORDS;

   ////////////////////////////////////////////////////////////////////////////////
   // ranking: 0..2 fixed, settable levels sit above them, masked by grouping

   function [4:0] rankOf;
      input [5:0] v;
      input [2:0] p;
      input [2:0] m;
      begin
         if (v == `PXC_VEC_RST)
            rankOf = 5'h00;
         else if (v == `PXC_VEC_NMI)
            rankOf = 5'h01;
         else if (v == `PXC_VEC_HARD)
            rankOf = 5'h02;
         else
            rankOf = `PXC_FIXED_LEVELS + {2'b00, p & m};
      end
   endfunction

   function [31:0] mergeBytes;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] stb;
      integer b;
      begin
         mergeBytes = old;
         for (b = 0; b < 4; b = b + 1)
            if (stb[b])
               mergeBytes[8*b +: 8] = dat[8*b +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   reg [NIRQ-1:0] irqMeta_ff, irqSync_ff;
   reg [20:0] sysPri_ff;
   reg [NIRQ*3-1:0] irqPri_ff;
   reg [NIRQ-1:0] irqEn_ff;
   reg [2:0] grp_ff;
   reg busEn_ff, memEn_ff, usgEn_ff, dbgEn_ff;
   reg [NVEC-1:0] pend_ff, active_ff;
   reg [1:0] state_ff;
   reg [3:0] cnt_ff;
   reg [7:0] awAddr_ff;
   reg awHave_ff;
   reg [31:0] wData_ff;
   reg [3:0] wStrb_ff;
   reg wHave_ff;

   // two flops before any logic sees a peripheral line
   always @(posedge mclk) begin
      if (srst) begin
         irqMeta_ff <= {NIRQ{1'b0}};
         irqSync_ff <= {NIRQ{1'b0}};
      end else begin
         irqMeta_ff <= irqLine;
         irqSync_ff <= irqMeta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-vector priority, selection and preemption test

   reg [NVEC*3-1:0] prioBits;
   reg [NVEC-1:0] eligible;
   reg [5:0] bestVec;
   reg [4:0] bestRank, bestPre, curPre, restPre, r;
   reg bestHit;
   reg [2:0] preMask;
   integer v, u, j;

   always @* begin
      prioBits = {NVEC*3{1'b0}};
      prioBits[3*`PXC_VEC_MEM +: 3] = sysPri_ff[2:0];
      prioBits[3*`PXC_VEC_BUS +: 3] = sysPri_ff[5:3];
      prioBits[3*`PXC_VEC_USG +: 3] = sysPri_ff[8:6];
      prioBits[3*`PXC_VEC_SVC +: 3] = sysPri_ff[11:9];
      prioBits[3*`PXC_VEC_DBG +: 3] = sysPri_ff[14:12];
      prioBits[3*`PXC_VEC_PSV +: 3] = sysPri_ff[17:15];
      prioBits[3*`PXC_VEC_TICK +: 3] = sysPri_ff[20:18];
      prioBits[NVEC*3-1:48] = irqPri_ff;
      // an interrupt needs its enable; system vectors are always eligible once pending
      eligible = pend_ff & {irqEn_ff & `PXC_IMPL_MASK, 16'hFFFF};
      // grouping: the low grp bits are subpriority and do not preempt
      preMask = 3'h7 << grp_ff;
      bestHit = 1'b0;
      bestVec = 6'h00;
      bestRank = `PXC_RANK_BASE;
      curPre = `PXC_RANK_BASE;
      restPre = `PXC_RANK_BASE;
      for (v = 0; v < NVEC; v = v + 1) begin
         r = rankOf(v[5:0], prioBits[3*v +: 3], 3'h7);
         // ascending scan with strict compare keeps the lower number on a tie
         if (eligible[v] && (!bestHit || r < bestRank)) begin
            bestHit = 1'b1;
            bestRank = r;
            bestVec = v[5:0];
         end
         r = rankOf(v[5:0], prioBits[3*v +: 3], preMask);
         // the runner-up is the level left once the top handler returns
         if (active_ff[v] && r < curPre) begin
            restPre = curPre;
            curPre = r;
         end else if (active_ff[v] && r < restPre) begin
            restPre = r;
         end
      end
      bestPre = rankOf(bestVec, prioBits[3*bestVec +: 3], preMask);
   end

   wire canTake = bestHit && (bestPre < curPre);
   wire chainOk = bestHit && (bestPre < restPre);

   // a synchronous fault that cannot preempt escalates
   function canRun;
      input [5:0] fv;
      input [NVEC*3-1:0] pb;
      input [2:0] pm;
      input [4:0] cp;
      begin
         canRun = rankOf(fv, pb[3*fv +: 3], pm) < cp;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus writes and reads

   wire wrGo = awHave_ff && wHave_ff && !s_axi_bvalid;
   wire [31:0] wMerged = mergeBytes(32'h00000000, wData_ff, wStrb_ff);
   wire wrIrqPri = awAddr_ff >= `PXC_OFS_IRQPRI && awAddr_ff <= `PXC_OFS_IRQPRI_END;
   wire wrCtrl = wrGo && awAddr_ff == `PXC_OFS_CTRL;
   wire swNmi = wrCtrl && wMerged[`PXC_CTRL_NMI];
   wire swPsvSet = wrCtrl && wMerged[`PXC_CTRL_PSVSET];
   wire swPsvClr = wrCtrl && wMerged[`PXC_CTRL_PSVCLR];
   wire wrMapped = wrCtrl || wrIrqPri || awAddr_ff == `PXC_OFS_SYSPRI ||
      awAddr_ff == `PXC_OFS_IRQEN0 || awAddr_ff == `PXC_OFS_IRQEN1;
   wire [2:0] wrWord = awAddr_ff[4:2];
   integer i;

   always @(posedge mclk) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PXC_RESP_OKAY;
         awHave_ff <= 1'b0;
         wHave_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h00000000;
         wStrb_ff <= 4'h0;
         sysPri_ff <= {7{`PXC_PRIO_RST}};
         irqPri_ff <= {NIRQ{`PXC_PRIO_RST}};
         irqEn_ff <= {NIRQ{1'b0}};
         grp_ff <= 3'h0;
         busEn_ff <= 1'b0;
         memEn_ff <= 1'b0;
         usgEn_ff <= 1'b0;
         dbgEn_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_ff <= s_axi_awaddr;
            awHave_ff <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
            wHave_ff <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrGo) begin
            awHave_ff <= 1'b0;
            wHave_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `PXC_RESP_OKAY : `PXC_RESP_SLVERR;
            if (wrCtrl) begin
               busEn_ff <= wMerged[`PXC_CTRL_BUSEN];
               memEn_ff <= wMerged[`PXC_CTRL_MEMEN];
               usgEn_ff <= wMerged[`PXC_CTRL_USGEN];
               dbgEn_ff <= wMerged[`PXC_CTRL_DBGEN];
               grp_ff <= wMerged[`PXC_CTRL_GRP_LSB +: 3];
            end
            if (awAddr_ff == `PXC_OFS_SYSPRI)
               sysPri_ff <= wMerged[20:0];
            if (awAddr_ff == `PXC_OFS_IRQEN0)
               irqEn_ff[31:0] <= wMerged & IMPL[31:0];
            if (awAddr_ff == `PXC_OFS_IRQEN1)
               irqEn_ff[NIRQ-1:32] <= wMerged[NIRQ-33:0] & IMPL[NIRQ-1:32];
            if (wrIrqPri)
               for (i = 0; i < 8; i = i + 1)
                  irqPri_ff[3*(8*wrWord+i) +: 3] <= wMerged[4*i +: 3];
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   reg [31:0] rdVal;
   reg rdOk;
   always @* begin
      rdOk = 1'b1;
      rdVal = 32'h00000000;
      case (s_axi_araddr)
         `PXC_OFS_CTRL: rdVal = {21'h000000, grp_ff, 1'b0, dbgEn_ff, usgEn_ff, memEn_ff,
            busEn_ff, 3'h0};
         `PXC_OFS_STAT: rdVal = {14'h0000, handlerMode_ff, state_ff, bestHit, bestVec,
            2'h0, vecNum_ff};
         `PXC_OFS_SYSPRI: rdVal = {11'h000, sysPri_ff};
         `PXC_OFS_IRQEN0: rdVal = irqEn_ff[31:0];
         `PXC_OFS_IRQEN1: rdVal = {16'h0000, irqEn_ff[NIRQ-1:32]};
         `PXC_OFS_PEND0: rdVal = pend_ff[47:16];
         `PXC_OFS_PEND1: rdVal = {16'h0000, pend_ff[63:48]};
         default: begin
            if (s_axi_araddr >= `PXC_OFS_IRQPRI && s_axi_araddr <= `PXC_OFS_IRQPRI_END)
               for (j = 0; j < 8; j = j + 1)
                  rdVal[4*j +: 3] = irqPri_ff[3*(8*s_axi_araddr[4:2]+j) +: 3];
            else
               rdOk = 1'b0;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PXC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdVal;
         s_axi_rresp <= rdOk ? `PXC_RESP_OKAY : `PXC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pending and active bits; every set is applied after every clear

   wire take = state_ff == S_RUN && canTake && !excReturn;
   wire retire = state_ff == S_RUN && excReturn && handlerMode_ff;
   reg [NVEC-1:0] nxt_pend, nxt_active, topMask;

   always @* begin
      nxt_pend = pend_ff;
      nxt_active = active_ff;
      topMask = {NVEC{1'b0}};
      // the handler that returns is the most urgent active one
      for (u = NVEC - 1; u >= 0; u = u - 1)
         if (active_ff[u] && rankOf(u[5:0], prioBits[3*u +: 3], preMask) == curPre)
            topMask = {{NVEC-1{1'b0}}, 1'b1} << u;
      if (state_ff == S_BOOT && cnt_ff == 4'h2)
         nxt_active = {NVEC{1'b0}};
      if (retire)
         nxt_active = active_ff & ~topMask;
      if (take || (retire && chainOk)) begin
         nxt_pend[bestVec] = 1'b0;
         nxt_active[bestVec] = 1'b1;
      end
      if (swPsvClr)
         nxt_pend[`PXC_VEC_PSV] = 1'b0;
      // a level that is still high re-pends; software must clear early
      for (u = 0; u < NIRQ; u = u + 1)
         if (irqSync_ff[u] && !nxt_active[16+u] && active_ff[16+u] == 1'b0)
            nxt_pend[16+u] = 1'b1;
      if (swNmi)
         nxt_pend[`PXC_VEC_NMI] = 1'b1;
      if (swPsvSet)
         nxt_pend[`PXC_VEC_PSV] = 1'b1;
      if (sysTickFire)
         nxt_pend[`PXC_VEC_TICK] = 1'b1;
      if (svcInstr)
         nxt_pend[`PXC_VEC_SVC] = 1'b1;
      if (busFaultImprecise)
         nxt_pend[busEn_ff ? `PXC_VEC_BUS : `PXC_VEC_HARD] = 1'b1;
      if (memFault)
         nxt_pend[memEn_ff && canRun(`PXC_VEC_MEM, prioBits, preMask, curPre) ?
            `PXC_VEC_MEM : `PXC_VEC_HARD] = 1'b1;
      if (busFaultPrecise)
         nxt_pend[busEn_ff && canRun(`PXC_VEC_BUS, prioBits, preMask, curPre) ?
            `PXC_VEC_BUS : `PXC_VEC_HARD] = 1'b1;
      if (usageFault)
         nxt_pend[usgEn_ff && canRun(`PXC_VEC_USG, prioBits, preMask, curPre) ?
            `PXC_VEC_USG : `PXC_VEC_HARD] = 1'b1;
      if (debugMonReq && dbgEn_ff && canRun(`PXC_VEC_DBG, prioBits, preMask, curPre))
         nxt_pend[`PXC_VEC_DBG] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // entry / return sequencer

   always @(posedge mclk) begin
      if (srst) begin
         pend_ff <= {NVEC{1'b0}};
         active_ff <= {{NVEC-2{1'b0}}, 2'b10};
         state_ff <= S_BOOT;
         cnt_ff <= 4'h0;
         stackPush_ff <= 1'b0;
         stackPop_ff <= 1'b0;
         vecFetch_ff <= 1'b0;
         vecNum_ff <= `PXC_VEC_SP;
         spLoad_ff <= 1'b0;
         handlerMode_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         active_ff <= nxt_active;
         vecFetch_ff <= 1'b0;
         spLoad_ff <= 1'b0;
         handlerMode_ff <= |nxt_active[NVEC-1:2];
         case (state_ff)
            S_BOOT: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h0) begin
                  vecFetch_ff <= 1'b1;
                  vecNum_ff <= `PXC_VEC_SP;
                  spLoad_ff <= 1'b1;
               end else if (cnt_ff == 4'h1) begin
                  vecFetch_ff <= 1'b1;
                  vecNum_ff <= `PXC_VEC_RST;
               end else begin
                  cnt_ff <= 4'h0;
                  state_ff <= S_RUN;
               end
            end
            S_RUN: begin
               if (take) begin
                  // fetch goes out with the first push, not after the last
                  vecFetch_ff <= 1'b1;
                  vecNum_ff <= bestVec;
                  stackPush_ff <= 1'b1;
                  cnt_ff <= STACK_CNT;
                  state_ff <= S_PUSH;
               end else if (retire && chainOk) begin
                  vecFetch_ff <= 1'b1;
                  vecNum_ff <= bestVec;
               end else if (retire) begin
                  stackPop_ff <= 1'b1;
                  cnt_ff <= STACK_CNT;
                  state_ff <= S_POP;
               end
            end
            S_PUSH: begin
               cnt_ff <= cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  stackPush_ff <= 1'b0;
                  state_ff <= S_RUN;
               end
            end
            S_POP: begin
               cnt_ff <= cnt_ff - 4'h1;
               if (cnt_ff == 4'h1) begin
                  stackPop_ff <= 1'b0;
                  state_ff <= S_RUN;
               end
            end
            default: state_ff <= S_RUN;
         endcase
      end
   end
endmodule // pxc_ctrl

/* File: pxc_chk_assertions.sv */
// checker for the exception controller's core strobes and register bus answers
// assumes one clock and a synchronous active-high reset; bound to pxc_ctrl below
`include "pxc_map.vh"
module pxc_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // core side
   input wire logic excReturn,
   input wire logic stackPush_ff,
   input wire logic stackPop_ff,
   input wire logic vecFetch_ff,
   input wire logic [5:0] vecNum_ff,
   input wire logic spLoad_ff,
   input wire logic handlerMode_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_push_len: assert property ($rose(stackPush_ff) |-> stackPush_ff [*8] ##1 !stackPush_ff)
      else $error("stack push not eight cycles");
   chk_pop_len: assert property ($rose(stackPop_ff) |-> stackPop_ff [*8] ##1 !stackPop_ff)
      else $error("stack pop not eight cycles");
   chk_fetch_push: assert property ($rose(stackPush_ff) |-> vecFetch_ff && vecNum_ff >= 6'h02)
      else $error("vector fetch not alongside first push");
   chk_push_pop: assert property (!(stackPush_ff && stackPop_ff))
      else $error("push and pop together");
   chk_boot_sp: assert property ($fell(srst) |=> spLoad_ff && vecFetch_ff && vecNum_ff == 6'h00)
      else $error("stack pointer load missing after reset");
   chk_boot_rst: assert property (spLoad_ff |=> vecFetch_ff && vecNum_ff == `PXC_VEC_RST)
      else $error("reset vector not fetched after stack load");
   chk_no_reserved: assert property (vecFetch_ff |-> !(vecNum_ff inside {[7:10], 13}))
      else $error("reserved vector fetched");
   chk_mode_entry: assert property (vecFetch_ff && vecNum_ff >= 6'h02 |-> handlerMode_ff)
      else $error("handler mode low on entry");
   chk_ret_answer: assert property (excReturn && handlerMode_ff && !stackPush_ff
      && !stackPop_ff && !vecFetch_ff |=> vecFetch_ff != stackPop_ff)
      else $error("return neither chained nor popped");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   chk_write_end: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   cover property (excReturn ##1 vecFetch_ff && !stackPush_ff);
   cover property ($rose(stackPop_ff));
   cover property (vecFetch_ff && vecNum_ff == `PXC_VEC_NMI);
endmodule // pxc_chk
bind pxc_ctrl pxc_chk u_chk (.*);

/* File: pxc_core_model.sv */
// core stand-in: runs each handler for HOLD idle cycles, then pulses its return
// assumes the controller's strobes are registered on mclk
module pxc_core_model #(
   parameter int HOLD = 40
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // controller strobes
   input wire logic stackPush_ff,
   input wire logic stackPop_ff,
   input wire logic vecFetch_ff,
   // handler end
   output logic excReturn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pushSeen_ff, popSeen_ff;
   int depth_ff, cnt_ff;
   always @(posedge mclk) begin
      pushSeen_ff <= stackPush_ff;
      popSeen_ff <= stackPop_ff;
      excReturn <= 1'b0;
      if (srst) begin
         depth_ff <= 0;
         cnt_ff <= 0;
      end else begin
         // a tail chain fetches without pushing, so depth follows push and pop only
         if (stackPush_ff && !pushSeen_ff) depth_ff <= depth_ff + 1;
         else if (stackPop_ff && !popSeen_ff) depth_ff <= depth_ff - 1;
         // never return while state moves: the controller ignores it then
         if (excReturn || vecFetch_ff || stackPush_ff || stackPop_ff || depth_ff == 0) begin
            cnt_ff <= 0;
         end else if (cnt_ff == HOLD) begin
            excReturn <= 1'b1;
            cnt_ff <= 0;
         end else begin
            cnt_ff <= cnt_ff + 1;
         end
      end
   end
endmodule // pxc_core_model

/* File: testbench.sv */
// testbench: register bus master, event and interrupt line driver, result tally
// assumes pxc_ctrl with the bound checker and the core model answering handlers
`include "pxc_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awAddr = 8'h00;
   logic [7:0] arAddr = 8'h00;
   logic [31:0] wData = 32'h0;
   logic awValid = 1'b0;
   logic wValid = 1'b0;
   logic arValid = 1'b0;
   logic [47:0] irqLine = 48'h0;
   logic [6:0] evt = 7'h00;
   logic awReady, wReady, bValid, arReady, rValid, excReturn;
   logic [1:0] bResp, rResp, r;
   logic [31:0] rData, d, w;
   logic stackPush, stackPop, vecFetch, spLoad, handlerMode, pushSeen, popSeen;
   logic [5:0] vecNum;
   logic [5:0] fetchQ[$];
   logic [47:0] mask = `PXC_IMPL_MASK;
   int err_total = 0;
   int tests_run = 0;
   int pushN = 0;
   int popN = 0;
   int n, p0;
   // exception table: control word, event input (7 = none), vector expected
   int evtT[12] = '{0, 0, 1, 2, 1, 3, 3, 4, 5, 6, 7, 7};
   int vecT[12] = '{4, 3, 5, 5, 3, 6, 3, 11, 12, 15, 14, 2};
   logic [31:0] ctlT[12] = '{32'h10, 32'h0, 32'h8, 32'h8, 32'h0, 32'h20, 32'h0, 32'h0,
      32'h40, 32'h0, 32'h2, 32'h1};
   ////////////////////////////////////////////////////////////////////////////////
   pxc_ctrl u_dut (
      .mclk(mclk), .srst(srst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
      .irqLine(irqLine), .memFault(evt[0]), .busFaultPrecise(evt[1]),
      .busFaultImprecise(evt[2]), .usageFault(evt[3]), .svcInstr(evt[4]),
      .debugMonReq(evt[5]), .sysTickFire(evt[6]), .excReturn(excReturn),
      .stackPush_ff(stackPush), .stackPop_ff(stackPop), .vecFetch_ff(vecFetch),
      .vecNum_ff(vecNum), .spLoad_ff(spLoad), .handlerMode_ff(handlerMode)
   );
   pxc_core_model #(.HOLD(40)) u_core (.mclk(mclk), .srst(srst), .stackPush_ff(stackPush),
      .stackPop_ff(stackPop), .vecFetch_ff(vecFetch), .excReturn(excReturn));
   initial forever #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (vecFetch === 1'b1) begin
         fetchQ.push_back(vecNum);
         // clearing at entry keeps a slow source from re-entering its handler
         if (vecNum >= 6'h10) irqLine[vecNum - 6'h10] <= 1'b0;
      end
      if (stackPush && !pushSeen) pushN++;
      if (stackPop && !popSeen) popN++;
      pushSeen <= stackPush;
      popSeen <= stackPop;
   end
   function automatic logic [5:0] expVec(input int k);
      return 6'(k + 16);
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axiWr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
      int k;
      k = 0;
      awAddr <= a;
      wData <= dv;
      awValid <= 1'b1;
      wValid <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (bValid !== 1'b1 && k < 200);
      if (bValid !== 1'b1) err_total++;
      rs = bResp;
   endtask
   task automatic axiRd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      int k;
      k = 0;
      arAddr <= a;
      arValid <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
         if (arReady) arValid <= 1'b0;
      end while (rValid !== 1'b1 && k < 200);
      if (rValid !== 1'b1) err_total++;
      dv = rData;
      rs = rResp;
   endtask
   task automatic expFetch(input logic [5:0] v);
      int k;
      k = 0;
      while (fetchQ.size() == 0 && k < 3000) begin
         @(posedge mclk);
         k++;
      end
      chk("vector", (fetchQ.size() > 0) ? {26'h0, fetchQ.pop_front()} : 32'hFFFFFFFF, {26'h0, v});
   endtask
   task automatic waitIdle();
      int k;
      k = 0;
      while ((handlerMode !== 1'b0 || stackPop !== 1'b0 || stackPush !== 1'b0) && k < 3000) begin
         @(posedge mclk);
         k++;
      end
      chk("handler mode", {31'h0, handlerMode}, 32'h0);
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // whole run needs well under 20000 cycles; this bound is 50000
   initial begin
      #400000;
      err_total++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h849FEDFF));
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      expFetch(`PXC_VEC_SP);
      expFetch(`PXC_VEC_RST);
      for (int i = 0; i < 6; i++) begin
         axiRd(8'(`PXC_OFS_IRQPRI + 4 * i), d, r);
         chk("irq priority", d, 32'h0);
      end
      axiRd(`PXC_OFS_SYSPRI, d, r);
      chk("handler priority", d, 32'h0);
      axiRd(8'h1C, d, r);
      chk("unmapped read", {30'h0, r}, {30'h0, `PXC_RESP_SLVERR});
      axiWr(8'h1C, 32'h1, r);
      chk("unmapped write", {30'h0, r}, {30'h0, `PXC_RESP_SLVERR});
      axiWr(`PXC_OFS_IRQEN0, 32'hFFFFFFFF, r);
      axiRd(`PXC_OFS_IRQEN0, d, r);
      chk("enable low", d, mask[31:0]);
      axiWr(`PXC_OFS_IRQEN1, 32'hFFFFFFFF, r);
      axiRd(`PXC_OFS_IRQEN1, d, r);
      chk("enable high", d, {16'h0, mask[47:32]});
      $display("done: reset values and map");
      axiWr(`PXC_OFS_IRQEN1, 32'h0, r);
      axiWr(`PXC_OFS_IRQEN0, 32'h3, r);
      p0 = pushN + popN;
      irqLine[1:0] <= 2'b11;
      expFetch(expVec(0));
      expFetch(expVec(1));
      waitIdle();
      chk("stack moves", 32'(pushN + popN - p0), 32'd2);
      $display("done: tie break and chaining");
      axiWr(`PXC_OFS_IRQPRI, 32'h03132500, r);
      axiRd(`PXC_OFS_IRQPRI, d, r);
      chk("priority word", d, 32'h03132500);
      axiWr(`PXC_OFS_IRQEN0, 32'h7C, r);
      irqLine[3:2] <= 2'b11;
      expFetch(expVec(3));
      expFetch(expVec(2));
      waitIdle();
      irqLine[4] <= 1'b1;
      expFetch(expVec(4));
      irqLine[6:5] <= 2'b11;
      expFetch(expVec(5));
      expFetch(expVec(6));
      waitIdle();
      $display("done: priority and preemption");
      for (int i = 0; i < 6; i++) begin
         do n = $urandom % 48; while (mask[n] !== 1'b1);
         axiWr(`PXC_OFS_IRQEN0, (n < 32) ? 32'h1 << n : 32'h0, r);
         axiWr(`PXC_OFS_IRQEN1, (n < 32) ? 32'h0 : 32'h1 << (n - 32), r);
         irqLine[n] <= 1'b1;
         expFetch(expVec(n));
         waitIdle();
      end
      $display("done: random interrupt numbers");
      w = $urandom & 32'h001FFFFF;
      axiWr(`PXC_OFS_SYSPRI, w, r);
      axiRd(`PXC_OFS_SYSPRI, d, r);
      chk("handler priority", d, w);
      for (int i = 0; i < 12; i++) begin
         axiWr(`PXC_OFS_CTRL, ctlT[i], r);
         if (evtT[i] < 7) begin
            evt[evtT[i]] <= 1'b1;
            @(posedge mclk);
            evt <= 7'h00;
         end
         expFetch(6'(vecT[i]));
         waitIdle();
      end
      $display("done: system exceptions");
      finish_test;
   end
endmodule // testbench
